/* shared/bcdc_pkg.sv */
// Constants shared by the decade up/down counter design
// Operation
// - Separate up and down clocks set direction
// - Count steps only on a clock rising edge while the other clock is high
// - Load low copies preset inputs, overrides clocks
// - Clear high zeroes count, beats load
// - Decade sequence: nine wraps zero, zero wraps nine
// - Up from invalid: 10-11-6, 12-13-4, 14-15-2
// - Down from invalid steps down to nine
// - Overflow low when bits0,3 set, up clock low
// - Underflow low when zero and down clock low
package bcdc_pkg;
	localparam int CNT_W = 4;
	localparam logic [3:0] CNT_ZERO = 4'h0;
	localparam logic [3:0] CNT_ONE = 4'h1;
	localparam logic [3:0] CNT_NINE = 4'h9;
	localparam logic [3:0] CNT_TEN = 4'hA;
	localparam logic [3:0] CNT_ELEVEN = 4'hB;
	localparam logic [3:0] CNT_TWELVE = 4'hC;
	localparam logic [3:0] CNT_THIRTEEN = 4'hD;
	localparam logic [3:0] CNT_FOURTEEN = 4'hE;
	localparam logic [3:0] CNT_FIFTEEN = 4'hF;
	localparam logic [3:0] CNT_TWO = 4'h2;
	localparam logic [3:0] CNT_FOUR = 4'h4;
	localparam logic [3:0] CNT_SIX = 4'h6;
	localparam int BIT_Q0 = 0;
	localparam int BIT_Q3 = 3;
	// Synchronised input vector layout
	localparam int NUM_IN = 8;
	localparam int IDX_UP = 0;
	localparam int IDX_DN = 1;
	localparam int IDX_CLR = 2;
	localparam int IDX_LD = 3;
	localparam int IDX_PRE = 4;
	// Idle levels: clocks high, clear low, load high, preset zero
	localparam logic [7:0] IN_RST = 8'h0B;
endpackage

/* logic/bcdc_sync.sv */
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module bcdc_sync
#(
	parameter logic RST_VAL = 1'b0
)
(
	input wire logic clock_i,
	input wire logic resetn_i,
	input wire logic async_i,
	output logic filt_o
);
	logic s1_ff;
	logic s2_ff;
	logic s3_ff;
	logic filt_ff;

	always_ff @(posedge clock_i)
	begin
		if (!resetn_i)
		begin
			s1_ff <= RST_VAL;
			s2_ff <= RST_VAL;
			s3_ff <= RST_VAL;
		end
		else
		begin
			s1_ff <= async_i;
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
		end
	end

	// A change counts only once stages two and three agree
	always_ff @(posedge clock_i)
	begin
		if (!resetn_i)
			filt_ff <= RST_VAL;
		else if (s2_ff == s3_ff)
			filt_ff <= s2_ff;
	end

	assign filt_o = filt_ff;
endmodule // bcdc_sync
`default_nettype wire

/* logic/bcdc_top.sv */
// Presettable decade up/down counter with terminal count outputs
`timescale 1ns/1ps
`default_nettype none
module bcdc_top
	import bcdc_pkg::*;
(
	input wire logic clock_i,
	input wire logic resetn_i,
	input wire logic up_clk_i,
	input wire logic down_clk_i,
	input wire logic clear_in_i,
	input wire logic load_n_i,
	input wire logic preset_bit0_i,
	input wire logic preset_bit1_i,
	input wire logic preset_bit2_i,
	input wire logic preset_bit3_i,
	output logic [CNT_W-1:0] count_out_o,
	output logic overflow_n_o,
	output logic underflow_n_o
);
	logic [NUM_IN-1:0] raw_in;
	logic [NUM_IN-1:0] filt;
	logic up_f;
	logic dn_f;
	logic clr_f;
	logic ld_f;
	logic [CNT_W-1:0] pre_f;
	logic up_prev_ff;
	logic dn_prev_ff;
	logic up_rise;
	logic dn_rise;
	logic [CNT_W-1:0] count_ff;
	logic [CNT_W-1:0] nxt_up;
	logic [CNT_W-1:0] nxt_dn;
	logic overflow_n_ff;
	logic underflow_n_ff;

	function automatic logic [CNT_W-1:0] up_map(input logic [CNT_W-1:0] q);
		case (q)
			CNT_NINE: up_map = CNT_ZERO;
			CNT_ELEVEN: up_map = CNT_SIX;
			CNT_THIRTEEN: up_map = CNT_FOUR;
			CNT_FIFTEEN: up_map = CNT_TWO;
			default: up_map = q + CNT_ONE;
		endcase
	endfunction

	function automatic logic [CNT_W-1:0] dn_map(input logic [CNT_W-1:0] q);
		if (q == CNT_ZERO)
			dn_map = CNT_NINE;
		else
			dn_map = q - CNT_ONE;
	endfunction

	assign raw_in = {preset_bit3_i, preset_bit2_i, preset_bit1_i, preset_bit0_i,
		load_n_i, clear_in_i, down_clk_i, up_clk_i};

	genvar gi;
	generate
		for (gi = 0; gi < NUM_IN; gi++)
		begin : g_sync
			bcdc_sync #(.RST_VAL(IN_RST[gi])) u_sync
			(
				.clock_i(clock_i),
				.resetn_i(resetn_i),
				.async_i(raw_in[gi]),
				.filt_o(filt[gi])
			);
		end
	endgenerate

	assign up_f = filt[IDX_UP];
	assign dn_f = filt[IDX_DN];
	assign clr_f = filt[IDX_CLR];
	assign ld_f = filt[IDX_LD];
	assign pre_f = filt[IDX_PRE +: CNT_W];

	always_ff @(posedge clock_i)
	begin
		if (!resetn_i)
		begin
			up_prev_ff <= IN_RST[IDX_UP];
			dn_prev_ff <= IN_RST[IDX_DN];
		end
		else
		begin
			up_prev_ff <= up_f;
			dn_prev_ff <= dn_f;
		end
	end

	assign up_rise = up_f & ~up_prev_ff;
	assign dn_rise = dn_f & ~dn_prev_ff;
	assign nxt_up = up_map(count_ff);
	assign nxt_dn = dn_map(count_ff);

	// Clear beats load, load beats any clock edge
	always_ff @(posedge clock_i)
	begin
		if (!resetn_i)
			count_ff <= CNT_ZERO;
		else if (clr_f)
			count_ff <= CNT_ZERO;
		else if (!ld_f)
			count_ff <= pre_f;
		else if (up_rise && dn_f)
			count_ff <= nxt_up;
		else if (dn_rise && up_f)
			count_ff <= nxt_dn;
	end

	// Terminal counts follow the count and the low phase of their clock
	always_ff @(posedge clock_i)
	begin
		if (!resetn_i)
		begin
			overflow_n_ff <= 1'b1;
			underflow_n_ff <= 1'b1;
		end
		else
		begin
			overflow_n_ff <= ~(count_ff[BIT_Q0] & count_ff[BIT_Q3] & ~up_f);
			underflow_n_ff <= ~((count_ff == CNT_ZERO) & ~dn_f);
		end
	end

	assign count_out_o = count_ff;
	assign overflow_n_o = overflow_n_ff;
	assign underflow_n_o = underflow_n_ff;

	sequence up_step_s;
		!clr_f && ld_f && up_rise && dn_f;
	endsequence

	sequence dn_step_s;
		!clr_f && ld_f && dn_rise && up_f;
	endsequence

	sequence no_step_s;
		!clr_f && ld_f && !(up_rise && dn_f) && !(dn_rise && up_f);
	endsequence

	clear_zeroes_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
		clr_f |=> count_out_o == CNT_ZERO)
		else $error("Clear did not zero the count");

	load_copies_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
		(!clr_f && !ld_f) |=> count_out_o == $past(pre_f))
		else $error("Load did not copy preset");

	up_step_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
		(up_step_s and (count_out_o < CNT_NINE)) |=> count_out_o == $past(count_out_o) + CNT_ONE)
		else $error("Up step gave wrong count");

	down_step_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
		(dn_step_s and (count_out_o != CNT_ZERO)) |=> count_out_o == $past(count_out_o) - CNT_ONE)
		else $error("Down step gave wrong count");

	count_hold_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
		no_step_s |=> $stable(count_out_o))
		else $error("Count changed without a clock edge");

	decade_wrap_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
		(up_step_s and (count_out_o == CNT_NINE)) |=> count_out_o == CNT_ZERO)
		else $error("Nine did not wrap to zero");

	invalid_up_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
		(up_step_s and (count_out_o == CNT_ELEVEN)) |=> count_out_o == CNT_SIX)
		else $error("Eleven did not step to six");

	overflow_out_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
		##1 overflow_n_o == !($past(count_out_o[BIT_Q0] & count_out_o[BIT_Q3] & ~up_f)))
		else $error("Overflow output wrong");

	underflow_out_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
		##1 underflow_n_o == !($past((count_out_o == CNT_ZERO) & ~dn_f)))
		else $error("Underflow output wrong");

	load_gates_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
		(!clr_f && !ld_f && up_rise) |=> count_out_o == $past(pre_f))
		else $error("Clock edge counted during load");
endmodule // bcdc_top
`default_nettype wire

/* verif/bcdc_src.sv */
// Count clock source standing in for an upstream stage
`timescale 1ns/1ps
`default_nettype none
module bcdc_src
(
	input wire logic clock_i,
	output logic up_o,
	output logic dn_o
);
	initial
	begin
		up_o = 1'b1;
		dn_o = 1'b1;
	end
	// One clock is driven low; the other is driven high
	task automatic drop(input logic up);
		@(posedge clock_i);
		up_o <= !up;
		dn_o <= up;
		repeat (6) @(posedge clock_i);
	endtask
	// Both clocks low, so the next rising edge on either is refused
	task automatic both_low();
		up_o <= 1'b0;
		dn_o <= 1'b0;
		repeat (6) @(posedge clock_i);
	endtask
	task automatic lift();
		up_o <= 1'b1;
		dn_o <= 1'b1;
		repeat (6) @(posedge clock_i);
	endtask
endmodule // bcdc_src
`default_nettype wire

/* verif/bcd_up_down_counter_test.sv */
// Self-checking bench for the decade up/down counter
`timescale 1ns/1ps
`default_nettype none
module bcd_up_down_counter_test;
	import bcdc_pkg::*;
	logic clock_i = 1'b0;
	logic resetn_i = 1'b0;
	logic clear = 1'b0;
	logic load_n = 1'b1;
	logic [3:0] pre = 4'h0;
	logic up, dn, ovf_n, unf_n;
	logic [3:0] cnt;
	int errors = 0;
	int check_count = 0;
	int cycles = 0;
	bcdc_src u_src (.clock_i(clock_i), .up_o(up), .dn_o(dn));
	bcdc_top u_dut (.clock_i(clock_i), .resetn_i(resetn_i), .up_clk_i(up), .down_clk_i(dn),
		.clear_in_i(clear), .load_n_i(load_n), .preset_bit0_i(pre[0]), .preset_bit1_i(pre[1]),
		.preset_bit2_i(pre[2]), .preset_bit3_i(pre[3]), .count_out_o(cnt),
		.overflow_n_o(ovf_n), .underflow_n_o(unf_n));
	initial
	begin
		forever #25 clock_i = ~clock_i;
	end
	task automatic cmp(input logic [3:0] got, input logic [3:0] exp);
		check_count++;
		if (got !== exp)
		begin
			errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic cmp_flag(input logic got, input logic exp);
		check_count++;
		if (got !== exp)
		begin
			errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic pulse(input logic u);
		u_src.drop(u);
		u_src.lift();
	endtask
	// Start value loaded through the preset pins
	task automatic load(input logic [3:0] v);
		pre <= v;
		repeat (2) @(posedge clock_i);
		load_n <= 1'b0;
		repeat (6) @(posedge clock_i);
		cmp(cnt, v);
		load_n <= 1'b1;
		repeat (6) @(posedge clock_i);
	endtask
	task automatic t_up();
		load(4'h8);
		pulse(1'b1);
		cmp(cnt, 4'h9);
		u_src.drop(1'b1);
		cmp(cnt, 4'h9);
		cmp_flag(ovf_n, 1'b0);
		u_src.lift();
		cmp(cnt, 4'h0);
		cmp_flag(ovf_n, 1'b1);
		$display("up wrap done");
	endtask
	task automatic t_dn();
		u_src.drop(1'b0);
		cmp_flag(unf_n, 1'b0);
		u_src.lift();
		cmp(cnt, 4'h9);
		cmp_flag(unf_n, 1'b1);
		$display("down wrap done");
	endtask
	task automatic t_bad();
		logic [3:0] ex[3] = '{4'h6, 4'h4, 4'h2};
		for (int i = 0; i < 3; i++)
		begin
			load(4'hA + 4'(2 * i));
			pulse(1'b1);
			cmp(cnt, 4'hB + 4'(2 * i));
			pulse(1'b1);
			cmp(cnt, ex[i]);
		end
		load(4'hF);
		for (int i = 14; i >= 9; i--)
		begin
			pulse(1'b0);
			cmp(cnt, 4'(i));
		end
		$display("invalid states done");
	endtask
	task automatic t_clr();
		pre <= 4'h5;
		clear <= 1'b1;
		load_n <= 1'b0;
		pulse(1'b1);
		cmp(cnt, 4'h0);
		clear <= 1'b0;
		pulse(1'b1);
		cmp(cnt, 4'h5);
		load_n <= 1'b1;
		pulse(1'b1);
		cmp(cnt, 4'h6);
		u_src.both_low();
		u_src.drop(1'b0);
		cmp(cnt, 4'h6);
		u_src.lift();
		cmp(cnt, 4'h5);
		$display("clear and load done");
	endtask
	task automatic report_and_stop();
		$display("checks=%0d errors=%0d", check_count, errors);
		if (errors == 0 && check_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	always @(posedge clock_i)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			errors++;
			report_and_stop();
		end
	end
	initial
	begin
		repeat (20) @(posedge clock_i);
		resetn_i <= 1'b1;
		repeat (2) @(posedge clock_i);
		cmp(cnt, 4'h0);
		t_up();
		t_dn();
		t_bad();
		t_clr();
		report_and_stop();
	end
endmodule // bcd_up_down_counter_test
`default_nettype wire
